/* File: src/spac_defs.vh */
// constants for the spi command and address pointer front end.
// assumes a 32-entry register map addressed by a five-bit pointer.
`ifndef SPAC_DEFS_VH
`define SPAC_DEFS_VH

// control byte layout
`define SPAC_CMD_BITS 4'h8
`define SPAC_CMD_DEV_HI 7
`define SPAC_CMD_DEV_LO 6
`define SPAC_CMD_REG_HI 5
`define SPAC_CMD_REG_LO 1
`define SPAC_CMD_RW 0
`define SPAC_RW_READ 1'b1
`define SPAC_DEV_DEFAULT 2'h1

// address map limits and lock
`define SPAC_ADC_ADDR 5'h00
`define SPAC_WR_FIRST 5'h08
`define SPAC_LOCK_FREE 5'h1F
`define SPAC_LOCK_KEY 8'hA5

// read loop codes
`define SPAC_RL_STATIC 2'h0
`define SPAC_RL_GROUPS 2'h1
`define SPAC_RL_TYPES 2'h2
`define SPAC_RL_FULL 2'h3

// data width codes and word lengths
`define SPAC_W_16 2'h0
`define SPAC_W_24 2'h1
`define SPAC_BITS_16 6'h10
`define SPAC_BITS_24 6'h18
`define SPAC_BITS_32 6'h20

// default set layouts: a set begins at every set bit
`define SPAC_FULL_STARTS 32'h0000_0001
`define SPAC_TYPE_STARTS 32'h0000_0101
`define SPAC_GROUP_STARTS 32'h0001_0101
`define SPAC_DEFINED_MASK 32'hFFFF_FFFF

`endif

/* File: src/spac_front_end.v */
// spi slave command front end: control byte decode, pointer, streaming.
// assumes sck, cs_n, sdi and sample_ready_n arrive asynchronously and are
// much slower than ref_clk; the register map sits outside on rd_/wr_ ports.
`timescale 1ns/10ps
`include "spac_defs.vh"

// Operation
// (R1) byte: device addr, register addr, rw lowest
// (R2) first eight bits are the control byte
// (R3) output tri-stated during control byte
// (R4) respond only when device address matches
// (R5) read first register, then continue incremented
// (R6) output changes on sck falling edge
// (R7) input sampled on sck rising edge
// (R8) output high impedance for whole write
// (R9) non-writable write: no change, pointer stays
// (R10) one control byte, loop until cs rises
// (R11) pointer advances within set, wraps at end
// (R12) increment skips undefined addresses
// (R13) read loop: static, groups, types, full
// (R14) write loop: static or types
// (R15) ignore input bits during continuous read
// (R16) idle-low: old msb, new msb at ready
// (R17) idle-high: last bit held after word
// (R18) lock key not 0xa5: only 0x1f writable
// (R19) host restarts after non-writable write
// (R20) words are 16, 24 or 32 bits
// (R21) cs rising edge aborts to idle
// (R22) rw one reads, zero writes
// (R23) address mismatch: ignore until cs rises
module spac_front_end #(
    parameter [1:0] DEV_ADDR = `SPAC_DEV_DEFAULT,
    parameter [31:0] DEFINED_MASK = `SPAC_DEFINED_MASK,
    parameter [31:0] GROUP_STARTS = `SPAC_GROUP_STARTS,
    parameter [31:0] TYPE_STARTS = `SPAC_TYPE_STARTS
) (
    input wire ref_clk,
    input wire rst_b,
    input wire ce,
    input wire cs_n,
    input wire sck,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe,
    input wire sample_ready_n,
    input wire [1:0] read_loop,
    input wire write_loop,
    input wire [1:0] width_sel,
    input wire [7:0] lock_key,
    output reg [4:0] rd_addr,
    input wire [31:0] rd_data,
    output wire wr_valid,
    input wire wr_ready,
    output wire [4:0] wr_addr,
    output wire [31:0] wr_data,
    output reg wr_drop
);

localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_CMD = 5'h02;
localparam [4:0] ST_READ = 5'h04;
localparam [4:0] ST_WRITE = 5'h08;
localparam [4:0] ST_IGNORE = 5'h10;

////////////////////////////////////////////////////////////////////////////
// functions

function [5:0] word_bits;
    input [1:0] sel;
    begin
        case (sel)
            `SPAC_W_16: word_bits = `SPAC_BITS_16; // [R20]
            `SPAC_W_24: word_bits = `SPAC_BITS_24; // [R20]
            default: word_bits = `SPAC_BITS_32; // [R20]
        endcase
    end
endfunction

// next defined address inside the set holding cur, wrapping to set start
function [4:0] next_in_set;
    input [4:0] cur;
    input [31:0] starts;
    integer i;
    reg [5:0] s;
    reg [5:0] e;
    reg [4:0] c1;
    reg [4:0] c2;
    reg f1;
    begin
        s = 6'h00;
        e = 6'h1F;
        c1 = cur;
        c2 = cur;
        f1 = 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            if (starts[i] && i <= cur)
                s = i[5:0];
        end
        for (i = 31; i > 0; i = i - 1) begin
            if (starts[i] && i > cur)
                e = i[5:0] - 6'h01;
        end
        for (i = 31; i >= 0; i = i - 1) begin
            if (DEFINED_MASK[i] && i > cur && i <= e) begin // [R12]
                c1 = i[4:0];
                f1 = 1'b1;
            end
            if (DEFINED_MASK[i] && i >= s && i <= cur) // [R12]
                c2 = i[4:0]; // [R11]
        end
        next_in_set = f1 ? c1 : c2; // [R11]
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// input synchronisers and edge detection

reg [1:0] cs_sy_q;
reg [1:0] sck_sy_q;
reg [1:0] sdi_sy_q;
reg [1:0] rdy_sy_q;
reg cs_d1_q;
reg sck_d1_q;
reg rdy_d1_q;

always @(posedge ref_clk) begin
    if (!rst_b) begin
        cs_sy_q <= 2'h3;
        sck_sy_q <= 2'h0;
        sdi_sy_q <= 2'h0;
        rdy_sy_q <= 2'h3;
        cs_d1_q <= 1'b1;
        sck_d1_q <= 1'b0;
        rdy_d1_q <= 1'b1;
    end else if (ce) begin
        cs_sy_q <= {cs_sy_q[0], cs_n};
        sck_sy_q <= {sck_sy_q[0], sck};
        sdi_sy_q <= {sdi_sy_q[0], sdi};
        rdy_sy_q <= {rdy_sy_q[0], sample_ready_n};
        cs_d1_q <= cs_sy_q[1];
        sck_d1_q <= sck_sy_q[1];
        rdy_d1_q <= rdy_sy_q[1];
    end
end

wire cs_s = cs_sy_q[1];
wire sck_s = sck_sy_q[1];
wire sdi_s = sdi_sy_q[1];
wire cs_fall = cs_d1_q & ~cs_s;
wire sck_rise = ~sck_d1_q & sck_s;
wire sck_fall = sck_d1_q & ~sck_s;
wire rdy_fall = rdy_d1_q & ~rdy_sy_q[1];

////////////////////////////////////////////////////////////////////////////
// pointer and write-address helpers

wire [5:0] wbits = word_bits(width_sel);
wire [5:0] wlast = wbits - 6'h01;
wire [31:0] wmask = (wbits == `SPAC_BITS_32) ? 32'hFFFF_FFFF :
    ((32'h0000_0001 << wbits) - 32'h0000_0001);

reg [4:0] rd_next;
always @* begin
    case (read_loop)
        `SPAC_RL_STATIC: rd_next = rd_addr; // [R13]
        `SPAC_RL_GROUPS: rd_next = next_in_set(rd_addr, GROUP_STARTS); // [R13]
        `SPAC_RL_TYPES: rd_next = next_in_set(rd_addr, TYPE_STARTS); // [R13]
        default: rd_next = next_in_set(rd_addr, `SPAC_FULL_STARTS); // [R13]
    endcase
end

wire [4:0] wr_next = write_loop ? next_in_set(rd_addr, TYPE_STARTS) :
    rd_addr; // [R14]
wire key_ok = (lock_key == `SPAC_LOCK_KEY);
wire addr_wr_ok = DEFINED_MASK[rd_addr] && (rd_addr >= `SPAC_WR_FIRST) &&
    (key_ok || rd_addr == `SPAC_LOCK_FREE); // [R9] [R18]

////////////////////////////////////////////////////////////////////////////
// two-entry write buffer; the spi side cannot be stalled, so a word that
// finds both entries taken with no pop in that cycle is dropped and flagged on wr_drop

reg [36:0] ent0_q;
reg [36:0] ent1_q;
reg [1:0] fill_q;
reg push;
reg [36:0] push_word;

assign wr_valid = (fill_q != 2'h0);
assign wr_addr = ent0_q[36:32];
assign wr_data = ent0_q[31:0];
wire pop = wr_valid & wr_ready;
wire push_ok = push & ((fill_q != 2'h2) | pop);

always @(posedge ref_clk) begin
    if (!rst_b) begin
        ent0_q <= 37'h0_0000_0000;
        ent1_q <= 37'h0_0000_0000;
        fill_q <= 2'h0;
        wr_drop <= 1'b0;
    end else if (ce) begin
        wr_drop <= push & ~push_ok;
        case ({push_ok, pop})
            2'b10: begin
                if (fill_q == 2'h0)
                    ent0_q <= push_word;
                else
                    ent1_q <= push_word;
                fill_q <= fill_q + 2'h1;
            end
            2'b01: begin
                ent0_q <= ent1_q;
                fill_q <= fill_q - 2'h1;
            end
            2'b11: begin
                if (fill_q == 2'h1)
                    ent0_q <= push_word;
                else begin
                    ent0_q <= ent1_q;
                    ent1_q <= push_word;
                end
            end
            default: fill_q <= fill_q;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// serial state machine

reg [4:0] st_q;
reg [5:0] in_cnt_q;
reg [5:0] out_cnt_q;
reg [7:0] cmd_sh_q;
reg [31:0] wsh_q;
reg [31:0] osh_q;
reg first_q;
reg idle_low_q;
reg hold_q;
reg prev_msb_q;

wire [7:0] cmd_byte = {cmd_sh_q[6:0], sdi_s};
wire [31:0] wr_word = {wsh_q[30:0], sdi_s} & wmask;
wire [31:0] rd_align = (rd_data & wmask) << (`SPAC_BITS_32 - wbits);

always @* begin
    push = 1'b0;
    push_word = {rd_addr, wr_word};
    if (st_q == ST_WRITE && sck_rise && in_cnt_q == wlast && addr_wr_ok)
        push = 1'b1; // [R9] [R18]
end

always @(posedge ref_clk) begin
    if (!rst_b) begin
        st_q <= ST_IDLE;
        in_cnt_q <= 6'h00;
        out_cnt_q <= 6'h00;
        cmd_sh_q <= 8'h00;
        wsh_q <= 32'h0000_0000;
        osh_q <= 32'h0000_0000;
        rd_addr <= 5'h00;
        sdo <= 1'b0;
        sdo_oe <= 1'b0;
        first_q <= 1'b1;
        idle_low_q <= 1'b1;
        hold_q <= 1'b0;
        prev_msb_q <= 1'b0;
    end else if (ce) begin
        if (cs_s) begin
            st_q <= ST_IDLE; // [R21]
            sdo_oe <= 1'b0; // [R21]
            hold_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (cs_fall) begin
                        st_q <= ST_CMD; // [R2]
                        in_cnt_q <= 6'h00;
                        idle_low_q <= ~sck_s;
                    end
                end
                ST_CMD: begin
                    sdo_oe <= 1'b0; // [R3]
                    if (sck_rise) begin
                        cmd_sh_q <= cmd_byte; // [R7]
                        in_cnt_q <= in_cnt_q + 6'h01;
                        if (in_cnt_q == {2'h0, `SPAC_CMD_BITS} - 6'h01) begin
                            in_cnt_q <= 6'h00; // [R2]
                            out_cnt_q <= 6'h00;
                            first_q <= 1'b1;
                            rd_addr <= cmd_byte[`SPAC_CMD_REG_HI:
                                `SPAC_CMD_REG_LO]; // [R1]
                            if (cmd_byte[`SPAC_CMD_DEV_HI:`SPAC_CMD_DEV_LO]
                                    != DEV_ADDR)
                                st_q <= ST_IGNORE; // [R4] [R23]
                            else if (cmd_byte[`SPAC_CMD_RW] == `SPAC_RW_READ)
                                st_q <= ST_READ; // [R22]
                            else
                                st_q <= ST_WRITE; // [R22]
                        end
                    end
                end
                ST_READ: begin
                    // sdi is not looked at here at all [R15]
                    if (sck_rise) begin
                        in_cnt_q <= in_cnt_q + 6'h01;
                        if (in_cnt_q == wlast) begin
                            in_cnt_q <= 6'h00;
                            rd_addr <= rd_next; // [R5] [R10] [R11]
                        end
                    end
                    if (sck_fall) begin
                        sdo_oe <= 1'b1;
                        if (hold_q) begin
                            hold_q <= 1'b0;
                            sdo <= rd_align[31];
                            osh_q <= rd_align << 1;
                            prev_msb_q <= rd_align[31];
                        end else if (out_cnt_q == 6'h00) begin
                            out_cnt_q <= wlast;
                            first_q <= 1'b0;
                            if (!first_q && idle_low_q &&
                                    rd_addr == `SPAC_ADC_ADDR) begin
                                sdo <= prev_msb_q; // [R16]
                                hold_q <= 1'b1; // [R16]
                            end else begin
                                sdo <= rd_align[31]; // [R5] [R6]
                                osh_q <= rd_align << 1;
                                prev_msb_q <= rd_align[31];
                            end
                        end else begin
                            sdo <= osh_q[31]; // [R6]
                            osh_q <= osh_q << 1;
                            out_cnt_q <= out_cnt_q - 6'h01;
                        end
                    end else if (hold_q && rdy_fall) begin
                        hold_q <= 1'b0; // [R16]
                        sdo <= rd_align[31]; // [R16]
                        osh_q <= rd_align << 1;
                        prev_msb_q <= rd_align[31];
                    end
                    // with sck idle high no edge follows the lsb, so the
                    // last shifted bit simply stays on the pin [R17]
                end
                ST_WRITE: begin
                    sdo_oe <= 1'b0; // [R8]
                    if (sck_rise) begin
                        wsh_q <= {wsh_q[30:0], sdi_s}; // [R7]
                        in_cnt_q <= in_cnt_q + 6'h01;
                        if (in_cnt_q == wlast) begin
                            in_cnt_q <= 6'h00;
                            if (addr_wr_ok)
                                rd_addr <= wr_next; // [R9] [R10] [R11]
                        end
                    end
                end
                ST_IGNORE: begin
                    sdo_oe <= 1'b0; // [R23]
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
end

endmodule // spac_front_end

/* File: verification/spac_checker.sv */
// checker on the ports of the spi front end.
// assumes sck is far slower than ref_clk.
`timescale 1ns/10ps
module spac_checker (
    input wire ref_clk,
    input wire rst_b,
    input wire cs_n,
    input wire sck,
    input wire sdo,
    input wire sdo_oe,
    input wire [7:0] lock_key,
    input wire [4:0] rd_addr,
    input wire wr_valid,
    input wire wr_ready,
    input wire [4:0] wr_addr,
    input wire [31:0] wr_data,
    input wire wr_drop
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // eight cycles cover the pin synchronisers and the output flop
    sequence s_cs_high;
        cs_n [*8];
    endsequence
    sequence s_stall;
        wr_valid && !wr_ready;
    endsequence
    ////////////////////////////////////////
    AST_CS_IDLE: assert property (
        s_cs_high |-> !sdo_oe)
        else $error("sdo driven while idle");
    AST_OE_RISE: assert property (
        $rose(sdo_oe) |-> !sck && !cs_n)
        else $error("sdo enabled off a falling sck");
    AST_OE_FALL: assert property (
        $fell(sdo_oe) |-> cs_n)
        else $error("sdo released inside a frame");
    AST_SDO_FALL: assert property (
        $changed(sdo) && sdo_oe && $past(sdo_oe) |-> !sck)
        else $error("sdo moved while sck high");
    AST_ADDR_RISE: assert property (
        $changed(rd_addr) |-> sck || cs_n)
        else $error("pointer moved off a rising sck");
    AST_WR_NO_OE: assert property (
        $rose(wr_valid) |-> !sdo_oe)
        else $error("write pushed during a read");
    AST_WR_HOLD: assert property (
        s_stall |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
        else $error("stalled entry changed");
    AST_WR_ADDR: assert property (
        $rose(wr_valid) |-> wr_addr >= 5'h08 &&
        (lock_key == 8'hA5 || wr_addr == 5'h1F))
        else $error("write to a locked address");
    AST_DROP: assert property (
        wr_drop |-> $past(wr_valid) && !$past(wr_ready))
        else $error("drop with room left");
endmodule // spac_checker

bind spac_front_end spac_checker u_spac_checker (
    .ref_clk(ref_clk), .rst_b(rst_b), .cs_n(cs_n), .sck(sck),
    .sdo(sdo), .sdo_oe(sdo_oe), .lock_key(lock_key),
    .rd_addr(rd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_drop(wr_drop)
);

/* File: verification/spac_host.sv */
// host model: spi master on cs, sck and sdi, either idle level.
// assumes the caller spaces frames; sck is still between them.
`timescale 1ns/10ps
module spac_host (
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire sdo,
    input wire sdo_oe
);
    localparam realtime HALF = 62.5;
    logic cpol = 1'b0;
    logic oe_hi = 1'b0;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // sdi set while sck low, taken at the rise
    task automatic shift(input int n, input logic [31:0] d,
                         output logic [31:0] q);
        q = 32'h0000_0000;
        for (int i = n - 1; i >= 0; i--) begin
            sck = 1'b0;
            sdi = d[i];
            #HALF;
            sck = 1'b1;
            q[i] = sdo_oe ? sdo : 1'bz;
            oe_hi = oe_hi | sdo_oe;
            #HALF;
        end
    endtask
    // one control byte opens the frame, msb first
    task automatic start(input logic [7:0] c, input logic p);
        logic [31:0] q;
        cpol = p;
        sck = p;
        oe_hi = 1'b0;
        #(4 * HALF);
        cs_n = 1'b0;
        #HALF;
        shift(8, {24'h00_0000, c}, q);
    endtask
    // sck back to its idle level with cs still low
    task automatic park();
        sck = cpol;
        #(2 * HALF);
    endtask
    // sdi turns over on release so no stale level lingers
    task automatic stop();
        sck = cpol;
        #HALF;
        cs_n = 1'b1;
        sdi = ~sdi;
        #(4 * HALF);
    endtask
endmodule // spac_host

/* File: verification/spac_front_end_bench.sv */
// bench: host model, register map stub and write consumer.
// assumes the map answers within one cycle of the pointer.
`timescale 1ns/10ps
module spac_front_end_bench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_ready = 1'b1;
    logic write_loop = 1'b1;
    logic [1:0] read_loop = 2'h2;
    logic [1:0] width_sel = 2'h0;
    logic [7:0] lock_key = 8'hA5;
    logic rdy_n = 1'b1;
    logic [31:0] adc_x = 32'h0000_0000;
    logic cs_n, sck, sdi, sdo, sdo_oe, wr_valid, wr_drop;
    logic [4:0] rd_addr, wr_addr;
    logic [31:0] rd_data, wr_data, q;
    logic [36:0] got[$], want[$];
    int errors = 0;
    int checks = 0;
    int drops = 0;
    always #4 ref_clk = ~ref_clk;
    // address repeated with fixed tails so a shifted bit shows
    function automatic logic [31:0] map(input logic [4:0] a);
        return {a, 3'h5, a, 3'h3, a, 3'h6, a, 3'h1};
    endfunction
    function automatic logic [31:0] rdw(input logic [4:0] a, input int w);
        return map(a) << (32 - w) >> (32 - w);
    endfunction
    // address 0 can flip bits to stand for a fresh sample
    assign rd_data = map(rd_addr) ^
        ((rd_addr == 5'h00) ? adc_x : 32'h0000_0000);
    always @(posedge ref_clk) begin
        if (wr_valid && wr_ready)
            got.push_back({wr_addr, wr_data});
        if (wr_drop)
            drops++;
    end
    ////////////////////////////////////////
    // address 0x08 left undefined so the pointer must skip it
    spac_front_end #(.DEFINED_MASK(32'hFFFF_FEFF)) u_spac_front_end (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .cs_n(cs_n),
        .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .sample_ready_n(rdy_n), .read_loop(read_loop),
        .write_loop(write_loop), .width_sel(width_sel),
        .lock_key(lock_key), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_drop(wr_drop)
    );
    spac_host u_spac_host (
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
    );
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [36:0] e, s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic cfg(input logic [1:0] rl, input logic wl,
                       input logic [1:0] ws, input logic [7:0] lk);
        @(posedge ref_clk);
        read_loop <= rl;
        write_loop <= wl;
        width_sel <= ws;
        lock_key <= lk;
        @(posedge ref_clk);
    endtask
    task automatic ex(input logic [4:0] a, input logic [15:0] d);
        want.push_back({a, 16'h0000, d});
    endtask
    task automatic wr(input logic [4:0] a, input int n,
                      input logic [15:0] d);
        u_spac_host.start({2'h1, a, 1'b0}, d[0]);
        for (int i = 0; i < n; i++)
            u_spac_host.shift(16, {16'h0000, d} + i, q);
        chk("write oe", 0, u_spac_host.oe_hi);
        u_spac_host.stop();
    endtask
    task automatic t_reads();
        logic [4:0] a0[4] = '{5'h09, 5'h0F, 5'h1F, 5'h1F};
        logic [4:0] a1[4] = '{5'h09, 5'h09, 5'h09, 5'h00};
        int w;
        for (int rl = 0; rl < 4; rl++) begin
            w = (rl == 0) ? 16 : (rl == 1) ? 24 : 32;
            cfg(rl[1:0], 1'b1, rl[1:0], 8'hA5);
            u_spac_host.start({2'h1, a0[rl], 1'b1}, rl[0]);
            chk("ctrl oe", 0, u_spac_host.oe_hi);
            u_spac_host.shift(w, 32'hAAAA_AAAA, q);
            chk("first word", rdw(a0[rl], w), q);
            u_spac_host.shift(w, 32'h5555_5555, q);
            chk("next word", rdw(a1[rl], w), q);
            if (rl[0])
                chk("held lsb", 1, sdo);
            u_spac_host.stop();
        end
    endtask
    task automatic t_other();
        u_spac_host.start({2'h2, 5'h09, 1'b1}, 1'b0);
        u_spac_host.shift(16, 32'h0000_FFFF, q);
        u_spac_host.stop();
        chk("foreign oe", 0, u_spac_host.oe_hi);
        u_spac_host.start({2'h0, 5'h10, 1'b0}, 1'b0);
        u_spac_host.shift(16, 32'h0000_1111, q);
        u_spac_host.stop();
    endtask
    task automatic t_writes();
        cfg(2'h2, 1'b1, 2'h0, 8'hA5);
        wr(5'h1E, 2, 16'h1234);
        ex(5'h1E, 16'h1234);
        ex(5'h1F, 16'h1235);
        wr(5'h1F, 2, 16'h2000);
        ex(5'h1F, 16'h2000);
        ex(5'h09, 16'h2001);
        cfg(2'h2, 1'b0, 2'h0, 8'hA5);
        wr(5'h10, 2, 16'h3000);
        ex(5'h10, 16'h3000);
        ex(5'h10, 16'h3001);
        wr(5'h05, 2, 16'h4000);
        wr(5'h08, 1, 16'h4100);
        wr(5'h0C, 1, 16'h4200);
        ex(5'h0C, 16'h4200);
        cfg(2'h2, 1'b1, 2'h0, 8'h00);
        wr(5'h10, 1, 16'h5000);
        wr(5'h1F, 1, 16'h5100);
        ex(5'h1F, 16'h5100);
    endtask
    task automatic t_stall();
        cfg(2'h2, 1'b1, 2'h0, 8'hA5);
        wr_ready <= 1'b0;
        wr(5'h10, 3, 16'h6000);
        ex(5'h10, 16'h6000);
        ex(5'h11, 16'h6001);
        chk("drops", 1, drops);
        @(posedge ref_clk);
        wr_ready <= 1'b1;
        for (int i = 0; i < 20 && wr_valid !== 1'b0; i++)
            @(posedge ref_clk);
        chk("drained", 0, wr_valid);
        if (wr_valid !== 1'b0)
            tally_and_finish();
    endtask
    task automatic t_abort();
        cfg(2'h0, 1'b1, 2'h0, 8'hA5);
        u_spac_host.start({2'h1, 5'h0A, 1'b1}, 1'b1);
        u_spac_host.shift(5, 32'h0000_0000, q);
        u_spac_host.stop();
        u_spac_host.start({2'h1, 5'h0B, 1'b1}, 1'b1);
        u_spac_host.shift(16, 32'h0000_0000, q);
        chk("after abort", rdw(5'h0B, 16), q);
        u_spac_host.stop();
    endtask
    task automatic t_ready();
        cfg(2'h0, 1'b1, 2'h0, 8'hA5);
        u_spac_host.start({2'h1, 5'h00, 1'b1}, 1'b0);
        u_spac_host.shift(16, 32'h0000_0000, q);
        chk("adc word", rdw(5'h00, 16), q);
        u_spac_host.park();
        chk("old msb", 0, sdo);
        @(posedge ref_clk);
        adc_x <= 32'h0000_8000;
        rdy_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rdy_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("new msb", 1, sdo);
        u_spac_host.shift(16, 32'h0000_0000, q);
        chk("next adc word", rdw(5'h00, 16) ^ 32'h0000_8000, q);
        u_spac_host.stop();
    endtask
    task automatic t_queue();
        chk("write count", want.size(), got.size());
        foreach (want[i])
            if (i < got.size())
                chk("write entry", want[i], got[i]);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reads();
        t_other();
        t_writes();
        t_stall();
        t_abort();
        t_ready();
        t_queue();
        tally_and_finish();
    end
endmodule // spac_front_end_bench
